/* src/sec_core.sv */
// Serial instruction front end and self-timed write control of a 1K-bit EEPROM
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Instructions are 9 bits in x16 mode, 10 bits in x8 mode, seven kinds.
// - Instruction, address and data bits sampled on each serial clock rise.
// - Output floats except during read data or busy/ready status.
// - After a self-timed cycle starts, select high shows low busy, high ready.
// - A one shifted in while ready floats the output on that rise.
// - Status output may be switched off only when ready, never while busy.
// - Fields: start one, two-bit opcode, address, then data for writes.
// - Read opcode 10; output leaves float after the address arrives.
// - Read sends a dummy zero, then the word most significant bit first.
// - Read bits change on the serial clock rising edge.
// - Write latch clears at reset and lock, sets on unlock; gates writes.
// - Reads work whatever the write latch state.
// - Opcode 00 with address 11 unlocks, 00 locks; rest don't care.
// - Word write is opcode 01 with address and data, then select low.
// - Select falling after a write starts a clear-then-store cycle.
// - Self-timed cycles finish without any further serial clock.
// - Word erase is opcode 11 with address, then select low.
// - Select falling after erase clears the word to all ones.
// - Opcode 00 with address 10 clears every location to all ones.
// - Opcode 00 with address 01 plus data fills every location.
module sec_core #(
  parameter int CYCLE_CLKS = sec_pkg::CYCLE_CLKS,
  parameter int WORDS = sec_pkg::WORDS_X16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic data_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Organization strap, high selects sixteen-bit words
  input wire logic width_select,
  // Status
  output logic busy,
  output logic write_enabled
);
  localparam int CW = $clog2(CYCLE_CLKS + 1);

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] sk_s;
    logic [1:0] di_s;
    logic [1:0] ws_s;
    logic sk_d;
    logic cs_d;
    sec_pkg::sec_state_t st;
    logic [4:0] cnt;
    logic [1:0] op;
    logic [6:0] addr;
    logic [15:0] data;
    logic [15:0] shift;
    logic rd_pend;
    logic wel;
    logic wide;
    sec_pkg::sec_work_t work;
    logic [CW-1:0] tmr;
    logic [6:0] sweep;
    logic out;
    logic oe;
    logic [WORDS-1:0][15:0] mem;
  } sec_core_st_t;

  sec_core_st_t s_r;
  sec_core_st_t s_nxt;
  logic sk_rise;
  logic cs_fall;
  logic cs_rise;
  logic bit_in;
  logic [5:0] waddr;
  logic [15:0] rword;
  logic [15:0] wval;
  logic [4:0] head_len;
  logic [4:0] data_len;
  sec_buf_if rbuf ();

  initial
  begin
    // Clear and fill sweep one word per clock, so the cycle must cover every word
    if (CYCLE_CLKS < WORDS || WORDS != 64)
      $error("sec_core needs 64 words and a cycle of at least one clock per word");
  end

  sec_buf2 #(.WIDTH(16), .DEPTH(2)) u_buf (
    .clk(clk),
    .reset(reset),
    .bi(rbuf.buf_side)
  );

  // Edges are found only on synchronised copies; first stages feed nothing else
  assign sk_rise = s_r.sk_s[1] && !s_r.sk_d;
  assign cs_fall = !s_r.cs_s[1] && s_r.cs_d;
  assign cs_rise = s_r.cs_s[1] && !s_r.cs_d;
  assign bit_in = s_r.di_s[1];
  // Header is opcode plus address; x8 has one more address bit
  assign head_len = s_r.wide ? 5'd8 : 5'd9;
  assign data_len = s_r.wide ? 5'd16 : 5'd8;
  assign waddr = s_r.wide ? s_r.addr[5:0] : s_r.addr[6:1];
  // Byte mode picks a half of the sixteen-bit storage word
  assign rword = s_r.wide ? s_r.mem[waddr] :
                 (s_r.addr[0] ? {8'h00, s_r.mem[waddr][15:8]} : {8'h00, s_r.mem[waddr][7:0]});
  assign rbuf.in_valid = s_r.rd_pend;
  assign rbuf.in_data = rword;
  assign rbuf.out_ready = (s_r.st == sec_pkg::ST_READ) && s_r.cnt == 5'd0 && sk_rise;

  // Write value merges a byte into the stored word in x8 mode
  always_comb
  begin
    wval = s_r.mem[waddr];
    if (s_r.wide)
      wval = (s_r.work == sec_pkg::WK_WORD || s_r.work == sec_pkg::WK_FILL) ? s_r.data : sec_pkg::ERASED_WORD;
    else if (s_r.addr[0])
      wval[15:8] = (s_r.work == sec_pkg::WK_WORD) ? s_r.data[7:0] : 8'hFF;
    else
      wval[7:0] = (s_r.work == sec_pkg::WK_WORD) ? s_r.data[7:0] : 8'hFF;
  end

  // Next state of the serial engine and self-timed cycle
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cs_s = {s_r.cs_s[0], chip_select};
    s_nxt.sk_s = {s_r.sk_s[0], serial_clock};
    s_nxt.di_s = {s_r.di_s[0], data_in};
    s_nxt.ws_s = {s_r.ws_s[0], width_select};
    s_nxt.sk_d = s_r.sk_s[1];
    s_nxt.cs_d = s_r.cs_s[1];
    if (rbuf.in_valid && rbuf.in_ready)
      s_nxt.rd_pend = 1'b0;
    unique case (s_r.st)
      sec_pkg::ST_IDLE:
      begin
        s_nxt.oe = 1'b0;
        if (s_r.cs_s[1] && sk_rise && bit_in)
        begin
          s_nxt.st = sec_pkg::ST_HEAD;
          s_nxt.cnt = 5'd0;
        end
      end
      sec_pkg::ST_HEAD:
      begin
        if (!s_r.cs_s[1])
          s_nxt.st = sec_pkg::ST_IDLE;
        else if (sk_rise)
        begin
          s_nxt.cnt = s_r.cnt + 5'd1;
          if (s_r.cnt < 5'd2)
            s_nxt.op = {s_r.op[0], bit_in};
          else
            s_nxt.addr = s_r.wide ? {1'b0, s_r.addr[4:0], bit_in} : {s_r.addr[5:0], bit_in};
          if (s_r.cnt == head_len - 5'd1)
          begin
            s_nxt.cnt = 5'd0;
            s_nxt.st = sec_pkg::ST_ARMED;
            unique case (s_r.op)
              sec_pkg::OP_READ:
              begin
                s_nxt.rd_pend = 1'b1;
                s_nxt.st = sec_pkg::ST_READ;
                s_nxt.out = 1'b0;
                s_nxt.oe = 1'b1;
              end
              sec_pkg::OP_WRITE:
              begin
                s_nxt.work = sec_pkg::WK_WORD;
                s_nxt.st = sec_pkg::ST_DATA;
              end
              sec_pkg::OP_ERASE:
                s_nxt.work = sec_pkg::WK_ERASE;
              sec_pkg::OP_EXT:
              begin
                unique case (s_r.wide ? s_r.addr[4:3] : s_r.addr[5:4])
                  sec_pkg::EXT_UNLOCK:
                  begin
                    s_nxt.wel = 1'b1;
                    s_nxt.st = sec_pkg::ST_DONE;
                  end
                  sec_pkg::EXT_LOCK:
                  begin
                    s_nxt.wel = 1'b0;
                    s_nxt.st = sec_pkg::ST_DONE;
                  end
                  sec_pkg::EXT_CLEAR:
                    s_nxt.work = sec_pkg::WK_CLEAR;
                  sec_pkg::EXT_FILL:
                  begin
                    s_nxt.work = sec_pkg::WK_FILL;
                    s_nxt.st = sec_pkg::ST_DATA;
                  end
                endcase
              end
            endcase
          end
        end
      end
      sec_pkg::ST_DATA:
      begin
        if (!s_r.cs_s[1])
          s_nxt.st = sec_pkg::ST_IDLE;
        else if (sk_rise)
        begin
          s_nxt.data = {s_r.data[14:0], bit_in};
          s_nxt.cnt = s_r.cnt + 5'd1;
          if (s_r.cnt == data_len - 5'd1)
            s_nxt.st = sec_pkg::ST_ARMED;
        end
      end
      sec_pkg::ST_READ:
      begin
        if (!s_r.cs_s[1])
        begin
          s_nxt.st = sec_pkg::ST_IDLE;
          s_nxt.oe = 1'b0;
        end
        else if (sk_rise && s_r.cnt == 5'd0 && rbuf.out_valid)
        begin
          // Dummy zero has been out; first data bit goes on this rise
          s_nxt.shift = s_r.wide ? rbuf.out_data : {rbuf.out_data[7:0], 8'h00};
          s_nxt.out = s_r.wide ? rbuf.out_data[15] : rbuf.out_data[7];
          s_nxt.cnt = 5'd1;
        end
        else if (sk_rise && s_r.cnt != 5'd0)
        begin
          s_nxt.shift = {s_r.shift[14:0], 1'b0};
          s_nxt.out = s_r.shift[14];
          s_nxt.cnt = (s_r.cnt == data_len) ? 5'd1 : s_r.cnt + 5'd1;
          if (s_r.cnt == data_len)
          begin
            // Sequential read stays out of scope: the word is sent once, then zeros
            s_nxt.out = 1'b0;
            s_nxt.cnt = data_len;
          end
        end
      end
      sec_pkg::ST_ARMED:
      begin
        if (cs_fall)
        begin
          if (s_r.wel)
          begin
            s_nxt.st = sec_pkg::ST_BUSY;
            s_nxt.tmr = CW'(CYCLE_CLKS);
            s_nxt.sweep = 7'd0;
          end
          else
            s_nxt.st = sec_pkg::ST_IDLE;
        end
        else if (sk_rise)
          s_nxt.st = sec_pkg::ST_DONE; // Extra clocks spoil the instruction
      end
      sec_pkg::ST_BUSY:
      begin
        // Runs from clk alone, serial clock ignored
        if (cs_rise)
        begin
          s_nxt.out = 1'b0;
          s_nxt.oe = 1'b1;
        end
        else if (!s_r.cs_s[1])
          s_nxt.oe = 1'b0;
        if (s_r.tmr != '0)
          s_nxt.tmr = s_r.tmr - CW'(1);
        if (s_r.work == sec_pkg::WK_CLEAR || s_r.work == sec_pkg::WK_FILL)
        begin
          // Whole array sweep, one word per clock
          if (s_r.sweep < 7'(WORDS))
          begin
            s_nxt.mem[s_r.sweep[5:0]] = (s_r.work == sec_pkg::WK_FILL) ?
              (s_r.wide ? s_r.data : {s_r.data[7:0], s_r.data[7:0]}) : sec_pkg::ERASED_WORD;
            s_nxt.sweep = s_r.sweep + 7'd1;
          end
        end
        else if (s_r.tmr == CW'(1))
          s_nxt.mem[waddr] = wval;
        if (s_r.tmr == CW'(1))
        begin
          s_nxt.st = sec_pkg::ST_DONE;
          s_nxt.out = 1'b1;
        end
      end
      sec_pkg::ST_DONE:
      begin
        // Ready: status shows high when selected, until a one is shifted in
        if (cs_rise)
        begin
          s_nxt.out = 1'b1;
          s_nxt.oe = 1'b1;
        end
        if (!s_r.cs_s[1])
        begin
          s_nxt.oe = 1'b0;
          if (cs_fall)
            s_nxt.oe = 1'b0;
        end
        else if (sk_rise && bit_in)
        begin
          s_nxt.oe = 1'b0;
          s_nxt.st = sec_pkg::ST_HEAD; // That one is also a start bit
          s_nxt.cnt = 5'd0;
        end
      end
      default:
        s_nxt.st = sec_pkg::ST_IDLE;
    endcase
    // Leaving done when deselected returns to plain idle
    if (s_r.st == sec_pkg::ST_DONE && cs_fall)
      s_nxt.st = sec_pkg::ST_IDLE;
    // Strap is taken only between instructions, from its synchronised copy
    if (s_r.st == sec_pkg::ST_IDLE)
      s_nxt.wide = s_r.ws_s[1];
  end

  // State register; memory keeps its contents through reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r.cs_s <= 2'h0;
      s_r.sk_s <= 2'h0;
      s_r.di_s <= 2'h0;
      s_r.ws_s <= 2'h3;
      s_r.sk_d <= 1'b0;
      s_r.cs_d <= 1'b0;
      s_r.st <= sec_pkg::ST_IDLE;
      s_r.cnt <= 5'h00;
      s_r.op <= 2'h0;
      s_r.addr <= 7'h00;
      s_r.data <= 16'h0000;
      s_r.shift <= 16'h0000;
      s_r.rd_pend <= 1'b0;
      s_r.wel <= 1'b0;
      s_r.wide <= 1'b1;
      s_r.work <= sec_pkg::WK_WORD;
      s_r.tmr <= '0;
      s_r.sweep <= 7'h00;
      s_r.out <= 1'b0;
      s_r.oe <= 1'b0;
      s_r.mem <= s_r.mem;
    end
    else
      s_r <= s_nxt;
  end

  assign serial_out = s_r.out;
  assign serial_out_oe = s_r.oe;
  assign busy = (s_r.st == sec_pkg::ST_BUSY);
  assign write_enabled = s_r.wel;
endmodule
`default_nettype wire

/* src/sec_pkg.sv */
// Package of constants and types for the serial EEPROM command logic
package sec_pkg;
  // Instruction field layout
  localparam int OPCODE_BITS = 2;
  localparam int ADDR_BITS_X16 = 6;
  localparam int ADDR_BITS_X8 = 7;
  localparam int DATA_BITS_X16 = 16;
  localparam int DATA_BITS_X8 = 8;
  localparam int WORDS_X16 = 64;
  // Opcodes
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // Leading address bits of the extended group
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_CLEAR = 2'h2;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;
  // Timing: program/erase pulse width and clock rate
  localparam int CLK_MHZ = 25;
  localparam int CYCLE_US = 5000;
  localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
  // Erased word value
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HEAD = 3'b001,
    ST_DATA = 3'b010,
    ST_READ = 3'b011,
    ST_ARMED = 3'b100,
    ST_BUSY = 3'b101,
    ST_DONE = 3'b110
  } sec_state_t;
  // Self-timed operation kinds
  typedef enum logic [1:0] {
    WK_WORD = 2'b00,
    WK_ERASE = 2'b01,
    WK_CLEAR = 2'b10,
    WK_FILL = 2'b11
  } sec_work_t;
endpackage

/* src/sec_buf_if.sv */
// Interface carrying read words from the core into the two-entry buffer
`timescale 1ns/1ns
`default_nettype none
interface sec_buf_if;
  logic in_valid;
  logic in_ready;
  logic [15:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [15:0] out_data;
  modport src (output in_valid, output in_data, input in_ready);
  modport buf_side (input in_valid, input in_data, output in_ready,
                    output out_valid, output out_data, input out_ready);
  modport snk (input out_valid, input out_data, output out_ready);
endinterface
`default_nettype wire

/* src/sec_buf2.sv */
// Two-entry valid/ready buffer for fetched read words
`timescale 1ns/1ns
`default_nettype none
module sec_buf2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Buffer ports
  sec_buf_if.buf_side bi
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [1:0] count;
    logic rd_ptr;
    logic wr_ptr;
  } sec_buf_st_t;

  sec_buf_st_t s_r;
  sec_buf_st_t s_nxt;
  logic push;
  logic pop;

  initial
  begin
    if (DEPTH != 2 || WIDTH < 1)
      $error("sec_buf2 serves exactly two entries");
  end

  // Honest full and empty drive the handshakes
  assign bi.in_ready = (s_r.count != 2'h2);
  assign bi.out_valid = (s_r.count != 2'h0);
  assign bi.out_data = s_r.mem[s_r.rd_ptr];
  assign push = bi.in_valid && bi.in_ready;
  assign pop = bi.out_valid && bi.out_ready;

  // Next state of the buffer
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wr_ptr] = bi.in_data;
      s_nxt.wr_ptr = ~s_r.wr_ptr;
    end
    if (pop)
      s_nxt.rd_ptr = ~s_r.rd_ptr;
    if (push && !pop)
      s_nxt.count = s_r.count + 2'h1;
    else if (pop && !push)
      s_nxt.count = s_r.count - 2'h1;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule
`default_nettype wire

/* dv/sec_core_sva.sv */
// Pin-level checks on the serial EEPROM command logic
`timescale 1ns/1ns
`default_nettype none
module sec_core_sva #(
  parameter int CYCLE_CLKS = sec_pkg::CYCLE_CLKS,
  parameter int WORDS = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic data_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic width_select,
  // Status
  input wire logic busy,
  input wire logic write_enabled
);
  // --------------------------------------------
  // Helper logic and checks
  // --------------------------------------------
  localparam int BUSY_MAX = 400;
  int busy_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Length of the current busy run, so a short cycle is seen without a long repetition
  always_ff @(posedge clk)
  begin
    if (reset || !busy)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= busy_cnt_r + 1;
  end
  a_float_deselected: assert property (!chip_select [*5] |-> !serial_out_oe)
    else $error("output driven while deselected");
  a_oe_needs_select: assert property ($rose(serial_out_oe) |-> chip_select)
    else $error("output enabled without select");
  a_busy_needs_latch: assert property ($rose(busy) |-> write_enabled)
    else $error("write cycle began with latch clear");
  a_busy_after_deselect: assert property ($rose(busy) |-> !chip_select && !$past(chip_select))
    else $error("write cycle began without select low");
  a_busy_min_len: assert property ($fell(busy) |-> busy_cnt_r >= CYCLE_CLKS - 1)
    else $error("write cycle too short");
  a_busy_ends_bounded: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
    else $error("write cycle never ended");
  a_status_while_busy: assert property ((busy && chip_select) [*6] |-> serial_out_oe && !serial_out)
    else $error("busy status not shown");
  a_latch_held_busy: assert property (busy |=> $stable(write_enabled))
    else $error("latch changed while busy");
endmodule
`default_nettype wire

/* dv/sec_host.sv */
// Behavioural host driving the three-wire serial bus
`timescale 1ns/1ns
`default_nettype none
module sec_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output var logic chip_select,
  output var logic serial_clock,
  output var logic data_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // --------------------------------------------
  // Bus tasks, all entered at a falling clk edge
  // --------------------------------------------
  // Serial clock rests low outside frames
  initial
  begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    data_in = 1'b0;
  end
  task automatic select;
    @(negedge clk);
    chip_select = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // Floating output reads as z so it never matches a driven bit
  task automatic shift(input logic [31:0] bits, input int n, output logic [31:0] rd);
    rd = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      data_in = bits[i];
      repeat (4) @(negedge clk);
      rd = {rd[30:0], serial_out_oe ? serial_out : 1'bz};
      serial_clock = 1'b1;
      repeat (4) @(negedge clk);
      serial_clock = 1'b0;
    end
  endtask
  // Released data line toggles so a stale level is never mistaken for a bit
  task automatic deselect;
    chip_select = 1'b0;
    data_in = ~data_in;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* dv/sec_core_tb_top.sv */
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ns
`default_nettype none
module sec_core_tb_top;
  // --------------------------------------------
  // Signals, design and host
  // --------------------------------------------
  // Short cycle for simulation, still long enough for the 64-word clear and fill sweep
  localparam int CYC = 80;
  localparam int CEIL = 20000;
  logic clk;
  logic reset;
  logic width_select;
  wire logic chip_select;
  wire logic serial_clock;
  wire logic data_in;
  logic serial_out;
  logic serial_out_oe;
  logic busy;
  logic write_enabled;
  logic [31:0] rd;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  sec_core #(.CYCLE_CLKS(CYC), .WORDS(64)) dut_u (.clk(clk), .reset(reset), .chip_select(chip_select),
    .serial_clock(serial_clock), .data_in(data_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .width_select(width_select), .busy(busy), .write_enabled(write_enabled));
  sec_host host_u (.clk(clk), .chip_select(chip_select), .serial_clock(serial_clock), .data_in(data_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  // --------------------------------------------
  // Shared tasks
  // --------------------------------------------
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmd(input logic [31:0] bits, input int n);
    host_u.select;
    host_u.shift(bits, n, rd);
    host_u.deselect;
  endtask
  // Seventeen extra clocks give the dummy zero and sixteen data bits
  task automatic rd16(input logic [5:0] a, input logic [15:0] exp);
    cmd({5'h0, 1'b1, 2'b10, a, 17'h0}, 26);
    chk("read word", rd[16:0], {1'b0, exp});
  endtask
  task automatic wr16(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    cmd({7'h0, 1'b1, op, a, d}, 25);
  endtask
  // Polls status through the busy cycle, then floats the output with a one
  task automatic poll;
    int k;
    k = 0;
    chk("busy after deselect", busy, 1'b1);
    host_u.select;
    repeat (6) @(negedge clk);
    chk("busy status", {serial_out_oe, serial_out}, 2'b10);
    while (busy === 1'b1 && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    repeat (6) @(negedge clk);
    chk("ready status", {serial_out_oe, serial_out}, 2'b11);
    host_u.shift(32'h1, 1, rd);
    chk("status floated", serial_out_oe, 1'b0);
    host_u.deselect;
  endtask
  // --------------------------------------------
  // Scenarios
  // --------------------------------------------
  task automatic t_clear;
    chk("reset outputs", {serial_out_oe, busy, write_enabled}, 3'b000);
    cmd(32'h130, 9);
    chk("latch set", write_enabled, 1'b1);
    cmd(32'h120, 9);
    poll;
    rd16(6'h05, 16'hFFFF);
  endtask
  // Second word shares no one bits with the first, so a missing auto-clear shows
  task automatic t_write;
    wr16(2'b01, 6'h06, 16'hA5C3);
    poll;
    rd16(6'h06, 16'hA5C3);
    wr16(2'b01, 6'h06, 16'h1234);
    poll;
    rd16(6'h06, 16'h1234);
    rd16(6'h05, 16'hFFFF);
    cmd({23'h0, 1'b1, 2'b11, 6'h06}, 9);
    poll;
    rd16(6'h06, 16'hFFFF);
  endtask
  task automatic t_fill_x8;
    wr16(2'b00, 6'h10, 16'h3C5A);
    poll;
    rd16(6'h00, 16'h3C5A);
    rd16(6'h3F, 16'h3C5A);
    width_select = 1'b0;
    cmd({22'h0, 1'b1, 2'b10, 7'h01, 9'h0}, 19);
    chk("byte read high", rd[8:0], {1'b0, 8'h3C});
    cmd({22'h0, 1'b1, 2'b10, 7'h7E, 9'h0}, 19);
    chk("byte read low", rd[8:0], {1'b0, 8'h5A});
    width_select = 1'b1;
  endtask
  task automatic t_busy;
    cmd({23'h0, 1'b1, 2'b11, 6'h02}, 9);
    host_u.select;
    host_u.shift(32'h1, 1, rd);
    chk("status kept while busy", {serial_out_oe, serial_out}, 2'b10);
    host_u.deselect;
    poll;
  endtask
  task automatic t_lock;
    cmd(32'h100, 9);
    chk("latch cleared", write_enabled, 1'b0);
    wr16(2'b01, 6'h01, 16'h0000);
    chk("locked write idle", busy, 1'b0);
    rd16(6'h01, 16'h3C5A);
  endtask
  task automatic t_abandon;
    host_u.select;
    host_u.shift(32'h13, 7, rd);
    host_u.deselect;
    chk("partial unlock", write_enabled, 1'b0);
    cmd(32'h130, 11);
    chk("zeros before start", write_enabled, 1'b1);
  endtask
  // --------------------------------------------
  // Clock, reset, sequence and timeout
  // --------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      mismatches++;
      test_done;
    end
  end
  initial
  begin
    reset = 1'b1;
    width_select = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_clear;
    t_write;
    t_fill_x8;
    t_busy;
    t_lock;
    t_abandon;
    test_done;
  end
endmodule
bind sec_core sec_core_sva #(.CYCLE_CLKS(CYCLE_CLKS), .WORDS(WORDS)) sva_u (.clk, .reset, .chip_select,
  .serial_clock, .data_in, .serial_out, .serial_out_oe, .width_select, .busy, .write_enabled);
`default_nettype wire
